/* File: rtl/bss_cfg.svh */
/*
 * Named constants of the buck switch sequencer: timing figures, counts and register offsets.
 * Assumes it is included by bare name after the package, and only for its definitions.
 */
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BSS_CLK_HZ 25000000
`define BSS_CLK_NS 40
`define BSS_SW_HZ 2000000
`define BSS_MINON_NS 40
`define BSS_SS_US 1000
`define BSS_PG_US 184

// ----------------------------------------------------------------------------
// Counts and widths
// ----------------------------------------------------------------------------
`define BSS_LIGHT_N 64
`define BSS_STAY_N 3
`define BSS_HIBER_N 5
`define BSS_REF_W 8

// ----------------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------------
`define BSS_ADR_CTRL 4'h0
`define BSS_ADR_STAT 4'h4
`define BSS_ADR_CNT 4'h8
`define BSS_CTRL_FPWM 0
`define BSS_CTRL_RST 1'h0

`endif

/* File: rtl/bss_pkg.sv */
/*
 * Types shared by the buck switch sequencer: comparator bundle, state codes, status word.
 * Assumes the comparator outputs are already synchronous to the core clock.
 */
package bss_pkg;

    // Comparator decisions from the analog side, all active high.
    typedef struct packed {
        logic fbBelowRef;
        logic pwmTrip;
        logic peakLimit;
        logic belowRecovery;
        logic peakLight;
        logic peak500;
        logic iZero;
        logic outAboveRise;
        logic outBelowFall;
    } bss_sense_t;

    // Gray along idle, high side, low side, floating, hibernate.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HS = 3'h1,
        ST_LS = 3'h3,
        ST_FLOAT = 3'h2,
        ST_HIBER = 3'h6,
        ST_CLIM = 3'h5
    } bss_state_t;

    // Status word as software reads it.
    typedef struct packed {
        logic [15:0] zero;
        logic [7:0] refLevel;
        logic hsOn;
        logic lsOn;
        logic pgArmed;
        logic ssDone;
        logic hibernating;
        logic pfmMode;
        logic pfmAllowed;
        logic captured;
    } bss_status_t;

endpackage : bss_pkg

/* File: rtl/bss_sequencer.sv */
/*
 * Switch sequencer of a synchronous step-down converter: gate drive, light-load mode,
 * soft-start reference, power-good and a classic Wishbone register slave.
 * Assumes comparator and pin inputs are synchronous to core_clk and the gate drivers
 * add their own analog dead time on top of the one idle cycle given here.
 */
`timescale 1ns/10ps
`include "bss_cfg.svh"

// Overview of operation
// [RULE1] Mode input is captured once enabled and supplies ready, held while enabled.
// [RULE2] Grounded mode input gives forced PWM; open input allows pulse skipping.
// [RULE3] Later changes on the mode input are ignored.
// [RULE4] Forced PWM switches every period and keeps low side on through zero current.
// [RULE5] Each clock fall turns high side on, held at least until the clock rise.
// [RULE6] PWM comparator trip ends on-time; low side on for rest of period.
// [RULE7] Peak current limit turns high side off and low side on at once.
// [RULE8] After a limit, low side stays on until the rise after recovery current.
// [RULE9] Pulse skipping starts after 64 light cycles and then zero current.
// [RULE10] In pulse skipping, feedback low fires high side until 500mA.
// [RULE11] After such a pulse low side runs to zero current, then both off.
// [RULE12] Pulse skipping blocks reverse current and skips pulses.
// [RULE13] Feedback high for 3 falls after floating keeps pulse skipping.
// [RULE14] Feedback high for 5 cycles after floating enters hibernate.
// [RULE15] Feedback low within 3 falls after floating leaves pulse skipping.
// [RULE16] Enable starts a 1ms ramp of the regulation reference from zero.
// [RULE17] Enable low holds both switches off and everything in shutdown.
// [RULE18] Power good releases above 93.5%, pulls low below 90%, holds between.
// [RULE19] Power good stays low until 184us after soft-start completes.
// [RULE20] During soft-start no current is sunk from a prebiased output.
// [RULE21] Any cycle reaching the light-load threshold clears the light counter.
// [RULE22] High and low side are never on together; break before make.
// [RULE23] Leaving pulse skipping resumes fixed frequency at the next clock fall.
module bss_sequencer
    import bss_pkg::*;
#(
    parameter int SW_PERIOD = `BSS_CLK_HZ / `BSS_SW_HZ,
    parameter int SS_CYCLES = `BSS_SS_US * (`BSS_CLK_HZ / 1000000),
    parameter int PG_CYCLES = `BSS_PG_US * (`BSS_CLK_HZ / 1000000),
    parameter int REF_W = `BSS_REF_W
) (
    input logic core_clk,
    input logic nrst,
    input logic enable,
    input logic suppliesReady,
    input logic modeOpen,
    input bss_sense_t sense,
    input logic powerOkIn,
    output logic powerOkOut,
    output logic powerOkOe,
    output logic hsGate,
    output logic lsGate,
    output logic [REF_W-1:0] refLevel,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [3:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ------------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------------
    localparam int MINON_CYC = (`BSS_MINON_NS + `BSS_CLK_NS - 1) / `BSS_CLK_NS;
    localparam int SS_STEP = ((SS_CYCLES >> REF_W) > 0) ? (SS_CYCLES >> REF_W) : 1;
    localparam int SWW = $clog2(SW_PERIOD);
    localparam int SSW = $clog2(SS_STEP + 1);
    localparam int PGW = $clog2(PG_CYCLES + 1);
    localparam int LW = $clog2(`BSS_LIGHT_N + 1);
    localparam int FW = $clog2(`BSS_HIBER_N + 1);
    localparam logic [SWW-1:0] SW_LAST = SWW'(SW_PERIOD - 1);
    localparam logic [SWW-1:0] SW_PRE_RISE = SWW'(MINON_CYC - 1);
    localparam logic [SSW-1:0] SS_LAST = SSW'(SS_STEP - 1);
    localparam logic [PGW-1:0] PG_LAST = PGW'(PG_CYCLES - 1);
    localparam logic [LW-1:0] LIGHT_N = LW'(`BSS_LIGHT_N);
    localparam logic [FW-1:0] STAY_N = FW'(`BSS_STAY_N);
    localparam logic [FW-1:0] HIBER_N = FW'(`BSS_HIBER_N);
    localparam logic [REF_W-1:0] REF_MAX = '1;

    // Address match shared by the write and the read path.
    function automatic logic bss_hit(input logic [3:0] adr, input logic [3:0] off);
        bss_hit = (adr == off);
    endfunction : bss_hit

    logic captured;
    logic pfmAllowed;
    logic [SWW-1:0] swCnt;
    logic swFall;
    logic swRise;
    logic [SSW-1:0] ssCnt;
    logic [PGW-1:0] pgCnt;
    logic pgArmed;
    logic [LW-1:0] lightCnt;
    logic [FW-1:0] floatFalls;
    logic minOnDone;
    logic clRecovered;
    logic pfmMode;
    logic pfmNext;
    logic forcePwm;
    bss_state_t state;
    bss_state_t stateNext;
    bss_status_t status;
    logic running;
    logic ssDone;
    logic lightDone;
    logic wbReq;

    assign running = enable && captured;
    assign ssDone = (refLevel == REF_MAX);
    assign lightDone = (lightCnt == LIGHT_N);
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Open drain: the pin is only ever pulled low, the enable does the work.
    assign powerOkOut = 1'h0;

    // ------------------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------------------
    // Latched once per enabled period; nothing else ever writes it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            captured <= 1'h0;
            pfmAllowed <= 1'h0;
        end else if (!enable) begin
            captured <= 1'h0;
            pfmAllowed <= 1'h0;
        end else if (!captured && suppliesReady) begin
            captured <= 1'h1; // [RULE1]
            pfmAllowed <= modeOpen; // [RULE2]
        end
    end

    mode_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
        captured && $past(captured) |-> $stable(pfmAllowed))
        else $error("Captured mode changed while enabled.");

    // ------------------------------------------------------------------------
    // Switching clock divider
    // ------------------------------------------------------------------------
    // The fall pulse opens a period; the rise pulse follows after the minimum on-time.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            swCnt <= '0;
            swFall <= 1'h0;
            swRise <= 1'h0;
        end else if (!running) begin
            swCnt <= '0;
            swFall <= 1'h0;
            swRise <= 1'h0;
        end else begin
            swCnt <= (swCnt == SW_LAST) ? '0 : swCnt + 1'h1;
            swFall <= (swCnt == SW_LAST);
            swRise <= (swCnt == SW_PRE_RISE);
        end
    end

    // ------------------------------------------------------------------------
    // Soft-start reference and power-good delay
    // ------------------------------------------------------------------------
    // The reference steps up once per SS_STEP cycles, so it tops out after REF_MAX steps, just short of SS_CYCLES.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ssCnt <= '0;
            refLevel <= '0;
        end else if (!running) begin
            ssCnt <= '0;
            refLevel <= '0;
        end else if (!ssDone) begin
            ssCnt <= (ssCnt == SS_LAST) ? '0 : ssCnt + 1'h1; // [RULE16]
            refLevel <= (ssCnt == SS_LAST) ? refLevel + 1'h1 : refLevel; // [RULE16]
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pgCnt <= '0;
            pgArmed <= 1'h0;
        end else if (!running) begin
            pgCnt <= '0;
            pgArmed <= 1'h0;
        end else if (ssDone && !pgArmed) begin
            pgCnt <= pgCnt + 1'h1;
            pgArmed <= (pgCnt == PG_LAST); // [RULE19]
        end
    end

    // Hysteresis: between the two thresholds the last decision stands.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            powerOkOe <= 1'h1;
        end else if (!pgArmed) begin
            powerOkOe <= 1'h1; // [RULE19]
        end else if (sense.outBelowFall) begin
            powerOkOe <= 1'h1; // [RULE18]
        end else if (sense.outAboveRise) begin
            powerOkOe <= 1'h0; // [RULE18]
        end
    end

    pg_early_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE19]
        !ssDone ##1 ssDone |-> powerOkOe [*8])
        else $error("Power good released too soon after soft-start.");

    pg_fall_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE18]
        pgArmed && sense.outBelowFall |=> powerOkOe)
        else $error("Power good not pulled low below falling threshold.");

    // ------------------------------------------------------------------------
    // Light-load counter
    // ------------------------------------------------------------------------
    // Counts whole periods without a light-threshold peak; any peak restarts it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lightCnt <= '0;
        end else if (!running || pfmMode || forcePwm || !pfmAllowed) begin
            lightCnt <= '0;
        end else if (sense.peakLight) begin
            lightCnt <= '0; // [RULE21]
        end else if (swFall && !lightDone) begin
            lightCnt <= lightCnt + 1'h1; // [RULE9]
        end
    end

    light_clear_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE21]
        sense.peakLight |=> lightCnt == '0)
        else $error("Light counter survived a heavy cycle.");

    // ------------------------------------------------------------------------
    // Switch state machine
    // ------------------------------------------------------------------------
    // Next state from comparators; the current limit overrides the loop.
    always_comb begin
        stateNext = state;
        pfmNext = pfmMode;
        if (!running) begin
            stateNext = ST_IDLE; // [RULE17]
            pfmNext = 1'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (swFall) begin
                        stateNext = ST_HS; // [RULE5] [RULE23]
                    end
                end
                ST_HS: begin
                    if (sense.peakLimit) begin
                        stateNext = ST_CLIM; // [RULE7]
                    end else if (pfmMode && sense.peak500) begin
                        stateNext = ST_LS; // [RULE10]
                    end else if (!pfmMode && sense.pwmTrip && minOnDone) begin
                        stateNext = ST_LS; // [RULE6] [RULE5]
                    end
                end
                ST_LS: begin
                    if (pfmMode && sense.iZero) begin
                        stateNext = ST_FLOAT; // [RULE11] [RULE12]
                    end else if (lightDone && sense.iZero) begin
                        stateNext = ST_FLOAT; // [RULE9]
                        pfmNext = 1'h1;
                    end else if (!ssDone && sense.iZero) begin
                        stateNext = ST_FLOAT; // [RULE20]
                    end else if (!pfmMode && swFall) begin
                        stateNext = ST_HS; // [RULE4]
                    end
                end
                ST_FLOAT: begin
                    if (swFall && !pfmMode) begin
                        stateNext = ST_HS;
                    end else if (swFall && sense.fbBelowRef && floatFalls < STAY_N) begin
                        stateNext = ST_IDLE; // [RULE15] [RULE23]
                        pfmNext = 1'h0;
                    end else if (swFall && sense.fbBelowRef) begin
                        stateNext = ST_HS; // [RULE13] [RULE10]
                    end else if (swFall && floatFalls == HIBER_N - 1'h1) begin
                        stateNext = ST_HIBER; // [RULE14]
                    end
                end
                ST_HIBER: begin
                    if (swFall && sense.fbBelowRef) begin
                        stateNext = ST_HS; // [RULE10]
                    end
                end
                ST_CLIM: begin
                    if (swRise && clRecovered) begin
                        stateNext = ST_LS; // [RULE8]
                    end
                end
                default: begin
                    stateNext = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            pfmMode <= 1'h0;
        end else begin
            state <= stateNext;
            pfmMode <= pfmNext;
        end
    end

    // Falls with feedback above reference since the switch node went floating.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            floatFalls <= '0;
        end else if (stateNext == ST_FLOAT && state != ST_FLOAT) begin
            floatFalls <= '0;
        end else if (swFall && (state == ST_FLOAT || state == ST_HIBER) &&
                     !sense.fbBelowRef && floatFalls != HIBER_N) begin
            floatFalls <= floatFalls + 1'h1; // [RULE13] [RULE14]
        end
    end

    // Minimum on-time and current-limit recovery trackers.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            minOnDone <= 1'h0;
            clRecovered <= 1'h0;
        end else begin
            if (stateNext == ST_HS && state != ST_HS) begin
                minOnDone <= 1'h0;
            end else if (swRise) begin
                minOnDone <= 1'h1; // [RULE5]
            end
            // Only a drop seen before the rising edge counts, never the same cycle.
            clRecovered <= (state == ST_CLIM) && (clRecovered || sense.belowRecovery); // [RULE8]
        end
    end

    // ------------------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------------------
    // Turning on waits for the other gate to be off, which costs one cycle of dead time.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hsGate <= 1'h0;
            lsGate <= 1'h0;
        end else begin
            hsGate <= (stateNext == ST_HS) && !lsGate; // [RULE22]
            lsGate <= (stateNext == ST_LS || stateNext == ST_CLIM) && !hsGate; // [RULE22]
        end
    end

    gates_excl_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE22]
        !(hsGate && lsGate) and !($fell(lsGate) && $rose(hsGate)))
        else $error("High and low side gates overlap.");

    shutdown_off_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE17]
        !enable |=> !hsGate && !lsGate && refLevel == '0)
        else $error("Switching while disabled.");

    climit_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
        state == ST_HS && running && sense.peakLimit |=> state == ST_CLIM && !hsGate ##1 lsGate)
        else $error("Current limit did not swap the switches.");

    cl_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE8]
        state == ST_CLIM && running && !clRecovered |=> state == ST_CLIM)
        else $error("Low side released before current recovered.");

    minon_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
        state == ST_LS && $past(state) == ST_HS && !pfmMode |-> $past(minOnDone))
        else $error("On-time ended before the clock rise.");

    pfm_entry_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE9]
        $rose(pfmMode) |-> $past(lightCnt) == LIGHT_N && state == ST_FLOAT)
        else $error("Pulse skipping entered without 64 light cycles.");

    pfm_zero_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE11]
        pfmMode && running && state == ST_LS && sense.iZero |=> state == ST_FLOAT ##1 !lsGate && !hsGate)
        else $error("Low side not released at zero current.");

    hiber_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE14]
        $rose(state == ST_HIBER) |-> floatFalls == HIBER_N && pfmMode)
        else $error("Hibernate entered on the wrong count.");

    pfm_exit_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE15]
        $fell(pfmMode) && running |-> state == ST_IDLE && $past(floatFalls) < STAY_N)
        else $error("Pulse skipping left on the wrong count.");

    // ------------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------------
    // Single-cycle answer; an unmapped address is acknowledged and reads as zero.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'h0;
        end else begin
            wb_ack_o <= wbReq;
        end
    end

    // Forcing PWM only blocks entry into pulse skipping, it never disturbs a cycle in flight.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            forcePwm <= `BSS_CTRL_RST;
        end else if (wbReq && wb_we_i && wb_sel_i[0] && bss_hit(wb_adr_i, `BSS_ADR_CTRL)) begin
            forcePwm <= wb_dat_i[`BSS_CTRL_FPWM];
        end
    end

    always_comb begin
        status = '0;
        status.refLevel = 8'(refLevel);
        status.hsOn = hsGate;
        status.lsOn = lsGate;
        status.pgArmed = pgArmed;
        status.ssDone = ssDone;
        status.hibernating = (state == ST_HIBER);
        status.pfmMode = pfmMode;
        status.pfmAllowed = pfmAllowed;
        status.captured = captured;
        status.zero[0] = powerOkIn;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wb_dat_o <= '0;
        end else if (wbReq && !wb_we_i && bss_hit(wb_adr_i, `BSS_ADR_CTRL)) begin
            wb_dat_o <= 32'(forcePwm);
        end else if (wbReq && !wb_we_i && bss_hit(wb_adr_i, `BSS_ADR_STAT)) begin
            wb_dat_o <= status;
        end else if (wbReq && !wb_we_i && bss_hit(wb_adr_i, `BSS_ADR_CNT)) begin
            wb_dat_o <= {16'h0000, 8'(floatFalls), 8'(lightCnt)};
        end else begin
            wb_dat_o <= '0;
        end
    end

endmodule : bss_sequencer

/* File: tb/bss_power_stage.sv */
/*
 * Behavioural power stage: inductor current, feedback and output comparators.
 * Assumes sequencer gates as inputs; one current count stands for 50mA.
 */
`timescale 1ns/10ps
module bss_power_stage
    import bss_pkg::*;
(
    input logic core_clk,
    input logic hsGate,
    input logic lsGate,
    input logic fbLow,
    input int pwmPeak,
    input int vOut,
    output bss_sense_t sense
);
    int iL = 0;

    // ------
    // Current ramps 100mA a cycle either way; with both gates off it freewheels down to zero.
    // ------
    // A slow rise keeps the shortest pulse under the light-load threshold, so light load is reachable.
    always @(posedge core_clk) begin
        if (hsGate) begin
            iL <= iL + 2;
        end else if (lsGate) begin
            iL <= (iL > -6) ? iL - 2 : iL;
        end else begin
            iL <= (iL > 2) ? iL - 2 : 0;
        end
    end

    // Comparators; negative current shows only while the low side is on and for the one cycle after it turns off.
    always_comb begin
        sense.fbBelowRef = fbLow;
        sense.pwmTrip = iL >= pwmPeak;
        sense.peakLimit = iL >= 34;
        sense.belowRecovery = iL < 28;
        sense.peakLight = iL >= 7;
        sense.peak500 = iL >= 10;
        sense.iZero = iL <= 0;
        sense.outAboveRise = vOut > 935;
        sense.outBelowFall = vOut < 900;
    end
endmodule : bss_power_stage

/* File: tb/testbench.sv */
/*
 * Self-checking bench of the sequencer with a behavioural power stage.
 * Assumes short soft-start and power-good counts set as parameters here.
 */
`timescale 1ns/10ps
module testbench
    import bss_pkg::*;
;
    typedef struct {logic [3:0] adr; logic we; logic [31:0] dat;} bss_row_t;
    logic core_clk = 0, nrst = 0, enable = 0, suppliesReady = 0, modeOpen = 1, fbLow = 0;
    logic wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, hsGate, lsGate, powerOkOut, powerOkOe;
    logic [3:0] wbAdr = 4'h0;
    logic [31:0] wbWdat = 32'h0, wbRdat, rd;
    logic [7:0] refLevel;
    int pwmPeak = 12, vOut = 0, errCount = 0, checked = 0, n;
    time t0;
    bss_sense_t sense;
    bss_row_t rows[6] = '{'{4'h0, 1'h1, 32'h1}, '{4'h0, 1'h0, 32'h1}, '{4'h0, 1'h1, 32'h0},
                          '{4'h0, 1'h0, 32'h0}, '{4'hC, 1'h1, 32'h5}, '{4'hC, 1'h0, 32'h0}};
    // Open-drain pin with its pull-up.
    wire powerOkPin = powerOkOe ? powerOkOut : 1'h1;

    always #20 core_clk = ~core_clk;

    bss_sequencer #(.SW_PERIOD(12), .SS_CYCLES(512), .PG_CYCLES(20)) i_bss_sequencer (
        .core_clk(core_clk), .nrst(nrst), .enable(enable), .suppliesReady(suppliesReady),
        .modeOpen(modeOpen), .sense(sense), .powerOkIn(powerOkPin), .powerOkOut(powerOkOut),
        .powerOkOe(powerOkOe), .hsGate(hsGate), .lsGate(lsGate), .refLevel(refLevel),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbWdat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck));
    bss_power_stage i_bss_power_stage (.core_clk(core_clk), .hsGate(hsGate), .lsGate(lsGate),
        .fbLow(fbLow), .pwmPeak(pwmPeak), .vOut(vOut), .sense(sense));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; holds the request until ack is sampled high.
    task automatic wb(input logic [3:0] adr, input logic we, input logic [31:0] dat);
        @(posedge core_clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= adr;
        wbWdat <= dat;
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'h1);
        rd = wbRdat;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
    endtask : wb

    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : printVerdict

    // Shoot-through watch on settled gates.
    always @(negedge core_clk) begin
        if (nrst) begin
            check(hsGate & lsGate, 1'h0);
        end
    end

    // ------
    // Main sequence
    // ------
    initial begin
        repeat (16) @(posedge core_clk);
        check({hsGate, lsGate, powerOkOe, refLevel}, 11'h100);
        nrst <= 1'h1;
        foreach (rows[i]) begin
            wb(rows[i].adr, rows[i].we, rows[i].dat);
            if (!rows[i].we) check(rd, rows[i].dat);
        end
        enable <= 1'h1;
        suppliesReady <= 1'h1;
        wb(4'h4, 1'h0, 32'h0);
        check(rd[1:0], 2'h3);
        modeOpen <= 1'h0;
        wb(4'h4, 1'h0, 32'h0);
        check(rd[1], 1'h1);
        repeat (3) @(posedge hsGate);
        t0 = $time;
        @(posedge hsGate);
        check(32'(($time - t0) / 40), 32'h0C);
        n = 0;
        while (refLevel !== 8'hFF && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        check(n > 300, 1'h1);
        vOut <= 950;
        repeat (18) @(posedge core_clk);
        check(powerOkOe, 1'h1);
        repeat (8) @(posedge core_clk);
        check(powerOkOe, 1'h0);
        wb(4'h4, 1'h0, 32'h0);
        check(rd[16], 1'h1);
        vOut <= 920;
        repeat (4) @(posedge core_clk);
        check(powerOkOe, 1'h0);
        vOut <= 890;
        repeat (4) @(posedge core_clk);
        check(powerOkOe, 1'h1);
        pwmPeak <= 40;
        @(posedge sense.peakLimit);
        repeat (2) @(negedge core_clk);
        check(hsGate, 1'h0);
        @(negedge core_clk);
        check(lsGate, 1'h1);
        @(posedge core_clk);
        pwmPeak <= 4;
        n = 0;
        do begin
            wb(4'h4, 1'h0, 32'h0);
        end while (rd[3] !== 1'h1 && ++n < 600);
        check(rd[3], 1'h1);
        check({hsGate, lsGate}, 2'h0);
        fbLow <= 1'h1;
        @(posedge sense.peak500);
        repeat (2) @(negedge core_clk);
        check(hsGate, 1'h0);
        repeat (40) @(posedge core_clk);
        wb(4'h4, 1'h0, 32'h0);
        check(rd[3:2], 2'h0);
        enable <= 1'h0;
        repeat (3) @(posedge core_clk);
        wb(4'h4, 1'h0, 32'h0);
        check({hsGate, lsGate, powerOkOe, rd[0], refLevel}, 12'h200);
        // Mode pin is now grounded, so a fresh enable must capture forced PWM.
        enable <= 1'h1;
        wb(4'h4, 1'h0, 32'h0);
        check(rd[1:0], 2'h1);
        printVerdict;
    end

    // Tests take about 1500 cycles; sixteen times that means a hang.
    initial begin
        repeat (24000) @(posedge core_clk);
        errCount++;
        printVerdict;
    end
endmodule : testbench
